// file: logic/stepper_pkg.sv
// constants, register map and types for the three-channel step/direction controller
// Operation
// - three channels, each with step and direction
// - only start/stop mode zero, no ramps
// - 16-bit absolute position, readable and writable
// - rate 50..2000 steps/s sets pulse rate
// - negative count drives direction high
// - rate and remaining count readable anytime
// - remaining count shrinks by one per step
// - writing zero count halts at once
package stepper_pkg;

    // ------------------------------------------------------------------
    // channel layout and timing
    // ------------------------------------------------------------------
    localparam int          NUM_MOTORS      = 3;
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          RATE_MIN        = 50;
    localparam int          RATE_MAX        = 2000;
    localparam int          PULSE_NS        = 10_000;
    localparam int          CLK_NS          = 50;
    localparam int          PULSE_CYC       = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          SETUP_NS        = 5_000;
    localparam int          SETUP_CYC       = (SETUP_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------------
    // register map: each channel owns a 16-byte block
    // ------------------------------------------------------------------
    localparam logic [7:0]  CH_STRIDE       = 8'h10;
    localparam logic [3:0]  OFF_POSITION    = 4'h0;
    localparam logic [3:0]  OFF_RATE        = 4'h4;
    localparam logic [3:0]  OFF_COUNT       = 4'h8;
    localparam logic [3:0]  OFF_SETUP       = 4'hc;
    localparam logic [15:0] RATE_RESET      = 16'h0032;
    localparam logic [15:0] POS_RESET       = 16'h0000;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam logic [1:0]  MODE_START_STOP = 2'b00;

    // channel sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_PULSE = 4'b1000
    } motor_state_t;

endpackage : stepper_pkg

// file: logic/motor_cfg_if.sv
// per-channel command and status bundle between register file and channel
`timescale 1ns/1ns
interface motor_cfg_if;
    logic        count_wr;   // one-cycle write of the remaining count
    logic [16:0] count_wdata;// signed count, bit 16 is the sign
    logic        pos_wr;     // one-cycle overwrite of the position
    logic [15:0] pos_wdata;  // new position
    logic [15:0] rate;       // steps per second
    logic [15:0] position;   // current absolute position
    logic [16:0] remaining;  // signed remaining count
    logic        moving;     // channel busy

    modport regs (output count_wr, count_wdata, pos_wr, pos_wdata, rate,
                  input position, remaining, moving);
    modport chan (input count_wr, count_wdata, pos_wr, pos_wdata, rate,
                  output position, remaining, moving);
endinterface : motor_cfg_if

// file: logic/motor_channel.sv
// one motor channel: rate timer, step pulse, direction and position
`timescale 1ns/1ns
module motor_channel (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    motor_cfg_if.chan  cfg,
    output logic       step_out,
    output logic       dir_out
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    stepper_pkg::motor_state_t state_q;   // sequencer
    logic [31:0]               timer_q;   // cycles left in current phase
    logic [16:0]               rem_q;     // signed remaining count
    logic [15:0]               pos_q;     // absolute position
    logic                      dir_q;     // latched direction

    // period in clock cycles for a rate, rate clamped to the legal span
    function automatic logic [31:0] period_cycles(input logic [15:0] r);
        logic [31:0] rr;
        rr = {16'h0000, r};
        if (rr < stepper_pkg::RATE_MIN) rr = stepper_pkg::RATE_MIN;
        if (rr > stepper_pkg::RATE_MAX) rr = stepper_pkg::RATE_MAX;
        period_cycles = stepper_pkg::CLK_HZ / rr;
    endfunction : period_cycles

    // magnitude of a signed count
    function automatic logic [16:0] mag(input logic [16:0] v);
        mag = v[16] ? 17'(-v) : v;
    endfunction : mag

    wire step_done = (state_q == stepper_pkg::ST_PULSE) && (timer_q == 32'h0000_0001);

    // ------------------------------------------------------------------
    // sequencer: setup, pulse, wait out rest of period, pulse again; zero write halts at once
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= stepper_pkg::ST_IDLE;
            timer_q <= 32'h0000_0000;
            dir_q   <= 1'b0;
        end else if (cfg.count_wr) begin
            if (cfg.count_wdata == 17'h0_0000) begin
                state_q <= stepper_pkg::ST_IDLE;
            end else begin
                dir_q   <= cfg.count_wdata[16];
                state_q <= stepper_pkg::ST_SETUP;
                timer_q <= 32'(stepper_pkg::SETUP_CYC);
            end
        end else begin
            case (state_q)
                stepper_pkg::ST_IDLE: begin
                    timer_q <= 32'h0000_0000;
                end
                stepper_pkg::ST_SETUP: begin
                    // direction has been stable for the setup time
                    if (timer_q == 32'h0000_0001) begin
                        state_q <= stepper_pkg::ST_PULSE;
                        timer_q <= 32'(stepper_pkg::PULSE_CYC);
                    end else begin
                        timer_q <= timer_q - 32'h0000_0001;
                    end
                end
                stepper_pkg::ST_PULSE: begin
                    if (timer_q == 32'h0000_0001) begin
                        if (mag(rem_q) == 17'h0_0001) begin
                            state_q <= stepper_pkg::ST_IDLE;
                        end else begin
                            state_q <= stepper_pkg::ST_WAIT;
                            timer_q <= period_cycles(cfg.rate)
                                       - 32'(stepper_pkg::PULSE_CYC);
                        end
                    end else begin
                        timer_q <= timer_q - 32'h0000_0001;
                    end
                end
                stepper_pkg::ST_WAIT: begin
                    // rest of the period, low phase of step
                    if (timer_q <= 32'h0000_0001) begin
                        state_q <= stepper_pkg::ST_PULSE;
                        timer_q <= 32'(stepper_pkg::PULSE_CYC);
                    end else begin
                        timer_q <= timer_q - 32'h0000_0001;
                    end
                end
                default: begin
                    state_q <= stepper_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // remaining count: loaded by software, counted toward zero per step
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rem_q <= 17'h0_0000;
        end else if (cfg.count_wr) begin
            rem_q <= cfg.count_wdata;
        end else if (step_done) begin
            rem_q <= rem_q[16] ? rem_q + 17'h0_0001 : rem_q - 17'h0_0001;
        end
    end

    // ------------------------------------------------------------------
    // absolute position; a software write beats a step in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_q <= stepper_pkg::POS_RESET;
        end else if (cfg.pos_wr) begin
            pos_q <= cfg.pos_wdata;
        end else if (step_done) begin
            pos_q <= dir_q ? pos_q - 16'h0001 : pos_q + 16'h0001;
        end
    end

    assign step_out      = (state_q == stepper_pkg::ST_PULSE);
    assign dir_out       = dir_q;
    assign cfg.position  = pos_q;
    assign cfg.remaining = rem_q;
    assign cfg.moving    = (state_q != stepper_pkg::ST_IDLE);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_pulse_start;
        !step_out ##1 step_out;
    endsequence

    // a count write, zero or not, may cut a pulse short on purpose, so the width check spares that cycle
    a_pulse_load: assert property (@(posedge aclk) disable iff (!aresetn)
        s_pulse_start |-> timer_q == 32'(stepper_pkg::PULSE_CYC))
        else $error("step pulse loaded with wrong width");
    a_pulse_width: assert property (@(posedge aclk) disable iff (!aresetn)
        step_out && !cfg.count_wr && timer_q != 32'h0000_0001 |=> step_out)
        else $error("step pulse cut short");
    a_zero_halts: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg.count_wr && cfg.count_wdata == 17'h0_0000 |=> !step_out && !cfg.moving)
        else $error("zero count did not halt");
    a_dir_steady: assert property (@(posedge aclk) disable iff (!aresetn)
        step_out |-> $stable(dir_out))
        else $error("direction changed during pulse");
    a_pos_steps: assert property (@(posedge aclk) disable iff (!aresetn)
        step_done && !cfg.pos_wr && !dir_q |=> pos_q == $past(pos_q) + 16'h0001)
        else $error("position did not advance");
    a_rem_counts: assert property (@(posedge aclk) disable iff (!aresetn)
        step_done && !cfg.count_wr |=> mag(rem_q) == mag($past(rem_q)) - 17'h0_0001)
        else $error("remaining count did not shrink");
endmodule : motor_channel

// file: logic/stepper_top.sv
// AXI4-Lite register file and three step/direction motor channels
`timescale 1ns/1ns
module stepper_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [2:0]       motor_step,
    output logic [2:0]       motor_dir
);
    // ------------------------------------------------------------------
    // write channel capture: address and data taken in either order
    // ------------------------------------------------------------------
    logic        aw_have_q;                 // write address held
    logic [7:0]  aw_addr_q;                 // captured write address
    logic        w_have_q;                  // write data held
    logic [31:0] w_data_q;                  // captured write data
    logic [3:0]  w_strb_q;                  // captured strobes
    logic        ar_have_q;                 // read pending
    logic [7:0]  ar_addr_q;                 // captured read address
    logic [15:0] rate_q   [3];              // per-channel step rate
    logic [1:0]  mode_q   [3];              // per-channel mode
    logic        do_write;                  // commit a write this cycle

    motor_cfg_if cfg_bus [3] ();

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !ar_have_q && !s_axi_rvalid;
    assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;

    // channel index of an aligned address; index 3 marks unmapped
    function automatic logic [1:0] chan_of(input logic [7:0] a);
        chan_of = (a[7:4] < 4'h3 && a[1:0] == 2'b00) ? a[5:4] : 2'b11;
    endfunction : chan_of

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // write response: OKAY for mapped words, SLVERR elsewhere
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= stepper_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (chan_of(aw_addr_q) == 2'b11) ? stepper_pkg::RESP_SLVERR
                                                          : stepper_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // per-channel registers and command strobes
    // ------------------------------------------------------------------
    for (genvar c = 0; c < stepper_pkg::NUM_MOTORS; c++) begin : g_ch
        wire hit = do_write && chan_of(aw_addr_q) == 2'(c);

        // rate and mode are plain storage; only mode zero is accepted
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rate_q[c] <= stepper_pkg::RATE_RESET;
                mode_q[c] <= stepper_pkg::MODE_START_STOP;
            end else if (hit && aw_addr_q[3:0] == stepper_pkg::OFF_RATE
                         && w_strb_q[1:0] == 2'b11) begin
                rate_q[c] <= w_data_q[15:0];
            end else if (hit && aw_addr_q[3:0] == stepper_pkg::OFF_SETUP
                         && w_strb_q[0]) begin
                mode_q[c] <= stepper_pkg::MODE_START_STOP;
            end
        end

        // count write launches the move; partial strobes are ignored
        assign cfg_bus[c].count_wr    = hit && aw_addr_q[3:0] == stepper_pkg::OFF_COUNT
                                        && w_strb_q[2:0] == 3'b111;
        assign cfg_bus[c].count_wdata = w_data_q[16:0];
        assign cfg_bus[c].pos_wr      = hit && aw_addr_q[3:0] == stepper_pkg::OFF_POSITION
                                        && w_strb_q[1:0] == 2'b11;
        assign cfg_bus[c].pos_wdata   = w_data_q[15:0];
        assign cfg_bus[c].rate        = rate_q[c];

        motor_channel u_chan (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .cfg      (cfg_bus[c]),
            .step_out (motor_step[c]),
            .dir_out  (motor_dir[c])
        );
    end

    // ------------------------------------------------------------------
    // read path: live position, rate, count (sign-extended), status
    // ------------------------------------------------------------------
    logic [31:0] rd_word [3];
    for (genvar c = 0; c < stepper_pkg::NUM_MOTORS; c++) begin : g_rd
        always_comb begin
            case (ar_addr_q[3:0])
                stepper_pkg::OFF_POSITION: rd_word[c] = {16'h0000, cfg_bus[c].position};
                stepper_pkg::OFF_RATE:     rd_word[c] = {16'h0000, rate_q[c]};
                stepper_pkg::OFF_COUNT:    rd_word[c] = {{15{cfg_bus[c].remaining[16]}},
                                                         cfg_bus[c].remaining};
                stepper_pkg::OFF_SETUP:    rd_word[c] = {23'h00_0000, cfg_bus[c].moving,
                                                         6'h00, mode_q[c]};
                default:                   rd_word[c] = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_have_q <= 1'b0;
            ar_addr_q <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ar_have_q <= 1'b1;
            ar_addr_q <= s_axi_araddr;
        end else begin
            ar_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= stepper_pkg::RESP_OKAY;
        end else if (ar_have_q) begin
            s_axi_rvalid <= 1'b1;
            if (chan_of(ar_addr_q) == 2'b11) begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= stepper_pkg::RESP_SLVERR;
            end else begin
                s_axi_rdata <= rd_word[chan_of(ar_addr_q)];
                s_axi_rresp <= stepper_pkg::RESP_OKAY;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_bresp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> ##1 s_axi_rvalid)
        else $error("read answer late");
endmodule : stepper_top

// file: dv/motor_driver_model.sv
// behavioural driver stages watching the step and direction pins
`timescale 1ns/1ns
module motor_driver_model (
    input wire logic       aclk,
    input wire logic [2:0] step,
    input wire logic [2:0] dir
);
    // ------------------------------------------------------------------
    // per-channel pulse bookkeeping
    // ------------------------------------------------------------------
    int         steps[3]  = '{0, 0, 0};  // rising edges seen
    int         width[3]  = '{0, 0, 0};  // last high length in cycles
    int         period[3] = '{0, 0, 0};  // last rise-to-rise gap in cycles
    int         run[3]    = '{0, 0, 0};  // cycles since last rise
    int         dir_bad   = 0;           // direction moved under a pulse
    logic [2:0] dir_at_rise = '0;        // direction latched at each rise
    logic [2:0] step_d    = '0;
    logic [2:0] dir_d     = '0;

    // a real stage latches direction at the rising step edge, so it must be still
    always @(posedge aclk) begin
        for (int c = 0; c < 3; c++) begin
            run[c]++;
            if (step[c] && !step_d[c]) begin
                steps[c]++;
                period[c]      = run[c];
                run[c]         = 0;
                dir_at_rise[c] = dir[c];
            end
            if (!step[c] && step_d[c]) width[c] = run[c];
            if (step[c] && dir[c] !== dir_d[c]) dir_bad++;
        end
        step_d = step;
        dir_d  = dir;
    end
endmodule : motor_driver_model

// file: dv/test_stepper_step_dir_controller.sv
// self-checking bench for the three-channel step/direction controller
`timescale 1ns/1ns
module test_stepper_step_dir_controller;
    // ------------------------------------------------------------------
    // clock, reset and bus signals
    // ------------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] motor_step, motor_dir;
    int failures = 0, cmp_count = 0, cyc = 0;
    localparam int PERIOD = stepper_pkg::CLK_HZ / stepper_pkg::RATE_MAX;

    always #25 aclk = ~aclk;

    stepper_top stepper_top_i (.*);
    motor_driver_model motor_driver_model_i (.aclk(aclk), .step(motor_step), .dir(motor_dir));

    // cycle budget; the tests need about 52300 cycles, running out counts as a mismatch
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 70000) begin
            failures++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // the caller resumes at a rising edge, so every drive below is an edge-time nba
    task automatic cycles(input int n);
        repeat (n) @(posedge aclk);
    endtask : cycles

    // handshakes are judged at the edge itself, where the design still shows pre-edge values
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // one quiet edge, so a following call never raises bready in this same step
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        d    = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic expect_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check(what, d, exp);
    endtask : expect_rd

    task automatic close_out();
        $display("counts: %0d comparisons, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // register rows: address, write flag, data, expected read and response
    // ------------------------------------------------------------------
    typedef struct {logic [7:0] a; bit w; logic [31:0] d, exp; logic [1:0] resp;} row_t;
    row_t rows[7] = '{
        '{8'h04, 0, 32'h0000_0000, 32'h0000_0032, 2'b00},  // rate reset
        '{8'h00, 0, 32'h0000_0000, 32'h0000_0000, 2'b00},  // position reset
        '{8'h08, 0, 32'h0000_0000, 32'h0000_0000, 2'b00},  // count reset
        '{8'h10, 1, 32'h0000_ffff, 32'h0000_ffff, 2'b00},  // position top value
        '{8'h24, 1, 32'h0000_07d0, 32'h0000_07d0, 2'b00},  // rate read back
        '{8'h0c, 1, 32'h0000_0003, 32'h0000_0000, 2'b00},  // mode forced zero
        '{8'h30, 1, 32'h0000_1234, 32'h0000_0000, 2'b10}   // unmapped place
    };

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        cycles(4);
        aresetn <= 1'b1;
        cycles(1);
        check("pins after reset", {26'h0, motor_step, motor_dir}, 32'h0);
        // table loop: writes, read-back and refusal of the unmapped place
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d, r);
                check("write resp", {30'h0, r}, {30'h0, rows[i].resp});
            end
            rd(rows[i].a, d, r);
            check("row data", d, rows[i].exp);
            check("row resp", {30'h0, r}, {30'h0, rows[i].resp});
        end
        $display("test rows done");
        // reverse move on channel 0, forward wrap on channel 1
        wr(8'h04, 32'h0000_07d0, r);
        wr(8'h08, 32'hffff_fffe, r);
        wr(8'h14, 32'h0000_07d0, r);
        wr(8'h18, 32'h0000_0002, r);
        cycles(5000);
        expect_rd("count mid move", 8'h08, 32'hffff_ffff);
        expect_rd("position mid move", 8'h00, 32'h0000_ffff);
        check("dir pins", {29'h0, motor_dir}, 32'h1);
        cycles(20000);
        expect_rd("count done", 8'h08, 32'h0);
        expect_rd("reverse position", 8'h00, 32'h0000_fffe);
        expect_rd("wrapped position", 8'h10, 32'h0000_0001);
        check("steps ch0", motor_driver_model_i.steps[0], 2);
        check("steps ch1", motor_driver_model_i.steps[1], 2);
        check("dir at rise", {29'h0, motor_driver_model_i.dir_at_rise}, 32'h1);
        check("pulse width", motor_driver_model_i.width[0], stepper_pkg::PULSE_CYC);
        check("step period", motor_driver_model_i.period[1], PERIOD);
        $display("test moves done");
        // stop in mid move on channel 2
        wr(8'h28, 32'h0000_0005, r);
        cycles(15000);
        expect_rd("moving flag", 8'h2c, 32'h0000_0100);
        wr(8'h28, 32'h0000_0000, r);
        cycles(12000);
        expect_rd("stopped count", 8'h28, 32'h0);
        expect_rd("stopped position", 8'h20, 32'h0000_0002);
        check("steps ch2", motor_driver_model_i.steps[2], 2);
        check("dir held", motor_driver_model_i.dir_bad, 0);
        $display("test stop done");
        // reset in mid pulse: reverse move on channel 1, then pins and registers go back
        wr(8'h18, 32'hffff_fffd, r);
        cycles(200);
        check("pins before reset", {26'h0, motor_step, motor_dir}, 32'h0000_0013);
        aresetn <= 1'b0;
        cycles(2);
        aresetn <= 1'b1;
        cycles(1);
        check("pins after mid reset", {26'h0, motor_step, motor_dir}, 32'h0);
        expect_rd("count after reset", 8'h18, 32'h0);
        expect_rd("rate after reset", 8'h14, 32'h0000_0032);
        expect_rd("position after reset", 8'h10, 32'h0);
        $display("test reset done");
        close_out();
    end
endmodule : test_stepper_step_dir_controller
